// ==== shared/pmt_params.svh ====
/*
 * Constants of the program memory and table read block: widths,
 * reset entry, table timing and programmer frame layout.
 * Assumes it is included once by bare name before any use.
 */
`ifndef PMT_PARAMS_SVH
`define PMT_PARAMS_SVH

// ------------------------------------------------------------
// Memory geometry (larger variant; smaller is 10 / 14)
// ------------------------------------------------------------
`define PMT_ADDR_W      11
`define PMT_WORD_W      15
`define PMT_LOW_W       8
`define PMT_RESET_VEC   11'h000

// ------------------------------------------------------------
// Table read timing, in instruction cycles
// ------------------------------------------------------------
`define PMT_TBL_CYCLES  2

// ------------------------------------------------------------
// Programmer frame: command, address, data, MSB first
// ------------------------------------------------------------
`define PMT_CMD_W       2
`define PMT_CMD_RD_PROG 2'h0
`define PMT_CMD_WR_PROG 2'h1
`define PMT_CMD_WR_EE   2'h2
`define PMT_CNT_W       5

`endif

// ==== shared/pmt_pkg.sv ====
/*
 * Types of the program memory and table read block.
 * Assumes pmt_params.svh is on the include path.
 */
`include "pmt_params.svh"

package pmt_pkg;

	// Table read request from the instruction decoder
	typedef struct packed {
		logic       cur_page;   // Pointer is an offset in the running page
		logic [7:0] dest;       // Data register that takes the low byte
		logic [7:0] ptr_low;
		logic [7:0] ptr_high;
	} pmt_tbl_req_type;

	// Table read answer towards the data memory
	typedef struct packed {
		logic [7:0] dest;
		logic [7:0] low_byte;
	} pmt_tbl_res_type;

	// Table sequencer states
	typedef enum logic {
		TS_IDLE,
		TS_READ
	} pmt_tbl_state_type;

endpackage

// ==== verilog/pmt_table_read.sv ====
/*
 * Program memory with instruction fetch, table read and in-circuit
 * programming access.
 * Assumes one clock at the instruction rate, a core that keeps
 * table requests apart by the busy flag, and programmer pins that
 * are asynchronous to the core clock.
 */
`timescale 1ns/1ps
`include "pmt_params.svh"

// What this block does
// [RULE_01] Program memory 1Kx14 or 2Kx15 words
// [RULE_02] Fetch by program counter, same memory
// [RULE_03] After reset first fetch is address zero
// [RULE_04] Table data anywhere, own table pointer
// [RULE_05] Address from low and high pointers
// [RULE_06] Low byte to register, high to latch
// [RULE_07] Missing latch bits read as zero
// [RULE_08] High latch is read-only to software
// [RULE_09] Current-page mode offsets from running page
// [RULE_10] Table instructions take two cycles
// [RULE_11] Software guards latch against interrupt reuse
// [RULE_12] Program and EEPROM written serially in-circuit
// [RULE_13] One two-way data line, programmer clock
// [RULE_14] Reset pin low hands pins to programmer
// [RULE_15] Board leaves programming pins undriven otherwise
// [RULE_16] Address is high pointer above low, truncated
module pmt_table_read #(
	parameter int ADDR_W = `PMT_ADDR_W,
	parameter int WORD_W = `PMT_WORD_W
) (
	input  wire logic                     sys_clk_i,
	input  wire logic                     arst_n_i,
	input  wire logic                     clk_en_i,
	input  wire logic                     fetch_req_i,
	input  wire logic [ADDR_W-1:0]        pc_i,
	output logic      [WORD_W-1:0]        instr_o,
	output logic                          instr_valid_o,
	input  wire logic                     tbl_req_i,
	input  wire pmt_pkg::pmt_tbl_req_type tbl_cmd_i,
	output logic                          tbl_busy_o,
	output logic                          tbl_done_o,
	output pmt_pkg::pmt_tbl_res_type      tbl_res_o,
	output logic      [7:0]               table_high_latch_o,
	input  wire logic                     external_reset_pin_n_i,
	input  wire logic                     port_a_bit2_prog_clock_i,
	input  wire logic                     port_a_bit0_prog_data_i,
	output logic                          port_a_bit0_prog_data_o,
	output logic                          port_a_bit0_prog_data_oe_o,
	output logic                          core_hold_o,
	output logic                          ee_wr_o,
	output logic      [7:0]               ee_addr_o,
	output logic      [7:0]               ee_data_o
);
	import pmt_pkg::*;

	localparam int FRAME_W = `PMT_CMD_W + ADDR_W + WORD_W;

	// ----------------------------------------------------------
	// Storage
	// ----------------------------------------------------------
	logic [WORD_W-1:0] mem [2**ADDR_W];                        // RULE_01

	// ----------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------
	logic [1:0] rst_sync;
	logic [2:0] clk_sync;
	logic [1:0] dat_sync;

	// Two flops per pin; the clock gets a third for edge finding
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync <= 2'h3;
			clk_sync <= 3'h0;
			dat_sync <= 2'h0;
		end else if (clk_en_i) begin
			rst_sync <= {rst_sync[0], external_reset_pin_n_i};
			clk_sync <= {clk_sync[1:0], port_a_bit2_prog_clock_i};
			dat_sync <= {dat_sync[0], port_a_bit0_prog_data_i};
		end
	end

	wire prog_mode = !rst_sync[1];                             // RULE_14
	wire pclk_rise = clk_sync[1] && !clk_sync[2];              // RULE_13
	wire pclk_fall = !clk_sync[1] && clk_sync[2];

	// ----------------------------------------------------------
	// Serial programming engine
	// ----------------------------------------------------------
	logic [FRAME_W-1:0]   shift_in;
	logic [`PMT_CNT_W-1:0] bit_cnt;
	logic [WORD_W-1:0]    shift_out;
	logic [`PMT_CNT_W-1:0] out_cnt;

	wire [FRAME_W-1:0]    next_shift = {shift_in[FRAME_W-2:0], dat_sync[1]};
	wire                  frame_end  = pclk_rise
		&& (bit_cnt == `PMT_CNT_W'(FRAME_W - 1)) && (out_cnt == '0);
	wire [`PMT_CMD_W-1:0] frm_cmd    = next_shift[FRAME_W-1 -: `PMT_CMD_W];
	wire [ADDR_W-1:0]     frm_addr   = next_shift[WORD_W +: ADDR_W];
	wire [WORD_W-1:0]     frm_data   = next_shift[WORD_W-1:0];
	wire                  prog_wr    = frame_end && (frm_cmd == `PMT_CMD_WR_PROG);
	wire                  prog_rd    = frame_end && (frm_cmd == `PMT_CMD_RD_PROG);

	// Frame collection; leaving programming drops a partial frame
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_in <= '0;
			bit_cnt  <= '0;
		end else if (clk_en_i) begin
			if (!prog_mode) begin
				bit_cnt <= '0;
			end else if (pclk_rise && out_cnt == '0) begin
				shift_in <= next_shift;                          // RULE_12
				bit_cnt  <= frame_end ? '0 : bit_cnt + 1'b1;
			end
		end
	end

	// Read-back: word goes out MSB first, changed on falling edges
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_out                  <= '0;
			out_cnt                    <= '0;
			port_a_bit0_prog_data_o    <= 1'b0;
			port_a_bit0_prog_data_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			if (!prog_mode) begin
				out_cnt                    <= '0;
				port_a_bit0_prog_data_oe_o <= 1'b0;
			end else if (prog_rd) begin
				shift_out <= mem[frm_addr];                      // RULE_13
				out_cnt   <= `PMT_CNT_W'(WORD_W + 1);            // Extra step: last rise not framed
			end else if (pclk_fall && out_cnt > `PMT_CNT_W'(1)) begin
				port_a_bit0_prog_data_o    <= shift_out[WORD_W-1];
				port_a_bit0_prog_data_oe_o <= 1'b1;
				shift_out <= {shift_out[WORD_W-2:0], 1'b0};
				out_cnt   <= out_cnt - 1'b1;
			end else if (pclk_fall) begin
				port_a_bit0_prog_data_oe_o <= 1'b0;              // Line back to programmer
				out_cnt                    <= '0;
			end
		end
	end

	// EEPROM writes are handed on to the data EEPROM controller
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ee_wr_o   <= 1'b0;
			ee_addr_o <= '0;
			ee_data_o <= '0;
		end else if (clk_en_i) begin
			ee_wr_o <= frame_end && (frm_cmd == `PMT_CMD_WR_EE); // RULE_12
			if (frame_end) begin
				ee_addr_o <= frm_addr[7:0];
				ee_data_o <= frm_data[7:0];
			end
		end
	end

	// Programmer writes are the only way a word changes
	always_ff @(posedge sys_clk_i) begin
		if (clk_en_i && prog_wr) begin
			mem[frm_addr] <= frm_data;                           // RULE_12
		end
	end

	// ----------------------------------------------------------
	// Instruction fetch
	// ----------------------------------------------------------
	logic reset_entry;

	wire [ADDR_W-1:0] fetch_addr = reset_entry ? ADDR_W'(`PMT_RESET_VEC) : pc_i; // RULE_03
	wire              fetch_go   = fetch_req_i && !prog_mode;

	// Entry flag rearms while held in reset by the programmer too
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reset_entry   <= 1'b1;
			instr_o       <= '0;
			instr_valid_o <= 1'b0;
			core_hold_o   <= 1'b1;
		end else if (clk_en_i) begin
			core_hold_o   <= prog_mode;                          // RULE_14
			instr_valid_o <= fetch_go;
			if (prog_mode) begin
				reset_entry <= 1'b1;                             // RULE_03
			end else if (fetch_go) begin
				instr_o     <= mem[fetch_addr];                  // RULE_02
				reset_entry <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------
	// Table read
	// ----------------------------------------------------------
	pmt_tbl_state_type tbl_state;
	logic [ADDR_W-1:0] tbl_addr;
	logic [7:0]        tbl_dest;

	// Full pointer: high byte above low byte, cut to memory width
	wire [15:0]        full_ptr  = {tbl_cmd_i.ptr_high, tbl_cmd_i.ptr_low};     // RULE_05
	wire [ADDR_W-1:0]  abs_addr  = full_ptr[ADDR_W-1:0];                        // RULE_16
	wire [ADDR_W-1:0]  page_addr = {pc_i[ADDR_W-1:8], tbl_cmd_i.ptr_low};       // RULE_09
	wire [ADDR_W-1:0]  next_addr = tbl_cmd_i.cur_page ? page_addr : abs_addr;   // RULE_04
	wire               tbl_take  = tbl_req_i && tbl_state == TS_IDLE && !prog_mode;
	wire [WORD_W-1:0]  tbl_word  = mem[tbl_addr];
	wire [15:0]        word_ext  = 16'(tbl_word);                               // RULE_07

	// Sequencer: take, then read; requests while busy are dropped
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tbl_state  <= TS_IDLE;
			tbl_busy_o <= 1'b0;
			tbl_addr   <= '0;
			tbl_dest   <= '0;
		end else if (clk_en_i) begin
			case (tbl_state)
				TS_IDLE: begin
					if (tbl_take) begin
						tbl_state  <= TS_READ;                       // RULE_10
						tbl_busy_o <= 1'b1;
						tbl_addr   <= next_addr;
						tbl_dest   <= tbl_cmd_i.dest;
					end
				end
				TS_READ: begin
					tbl_state  <= TS_IDLE;
					tbl_busy_o <= 1'b0;
				end
				default: begin
					tbl_state  <= TS_IDLE;
					tbl_busy_o <= 1'b0;
				end
			endcase
		end
	end

	// Answer and latch; no software path writes the latch
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tbl_done_o         <= 1'b0;
			tbl_res_o          <= '0;
			table_high_latch_o <= '0;
		end else if (clk_en_i) begin
			tbl_done_o <= tbl_state == TS_READ;
			if (tbl_state == TS_READ) begin
				tbl_res_o.dest     <= tbl_dest;                  // RULE_06
				tbl_res_o.low_byte <= tbl_word[7:0];
				table_high_latch_o <= word_ext[15:8];            // RULE_08
			end
		end
	end

	// ----------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------
	a_first_fetch_vector: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_03
		(clk_en_i && fetch_go && reset_entry) |=> instr_o == $past(mem[0]))
		else $error("first fetch did not read the reset entry");

	a_fetch_by_pc: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_02
		(clk_en_i && fetch_go && !reset_entry && !prog_wr)
		|=> instr_o == mem[$past(pc_i)])
		else $error("fetched word does not match program counter");

	a_table_two_cycles: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_10
		(clk_en_i && tbl_take) ##1 clk_en_i[*1] |=> tbl_done_o)
		else $error("table answer not two cycles after request");

	a_table_low_byte: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_06
		(clk_en_i && tbl_state == TS_READ && !prog_wr)
		|=> tbl_res_o.low_byte == mem[$past(tbl_addr)][7:0])
		else $error("low byte does not match addressed word");

	a_latch_zero_fill: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_07
		tbl_done_o |-> (16'({table_high_latch_o, 8'h00}) >> WORD_W) == 16'h0000)
		else $error("unused latch bits not zero");

	a_latch_read_only: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_08
		!(clk_en_i && tbl_state == TS_READ) |=> $stable(table_high_latch_o))
		else $error("latch changed without a table read");

	a_page_offset: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_09
		(clk_en_i && tbl_take && tbl_cmd_i.cur_page)
		|=> tbl_addr == {$past(pc_i[ADDR_W-1:8]), $past(tbl_cmd_i.ptr_low)})
		else $error("current page address wrong");

	a_full_pointer: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_16
		(clk_en_i && tbl_take && !tbl_cmd_i.cur_page)
		|=> tbl_addr == $past(full_ptr[ADDR_W-1:0]))
		else $error("full pointer address wrong");

	a_hold_in_prog: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_14
		(clk_en_i && prog_mode) |=> core_hold_o && !instr_valid_o && !tbl_busy_o)
		else $error("core not held while programming");

	a_pin_released: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RULE_13
		!prog_mode ##1 clk_en_i |=> !port_a_bit0_prog_data_oe_o)
		else $error("data pin driven outside programming");

	c_table_read: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		tbl_take ##1 clk_en_i ##1 tbl_done_o);
	c_page_read: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		tbl_take && tbl_cmd_i.cur_page);
	c_prog_write: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) prog_wr);
	c_prog_read: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) prog_rd);

endmodule // pmt_table_read

// ==== tb/pmt_programmer.sv ====
/*
 * Behavioural in-circuit programmer: owns the reset pin, the serial
 * clock and its side of the two-way data line.
 * Assumes the bench calls its tasks one at a time and feeds line_o
 * into the device's data pin input.
 */
`timescale 1ns/1ps

module pmt_programmer #(
	parameter int HALF_NS = 400
) (
	input  wire logic dev_data_i,
	input  wire logic dev_oe_i,
	output logic      reset_pin_n_o,
	output logic      clock_o,
	output logic      line_o
);
	logic drv_en;
	logic drv_val;
	logic last_v;

	// ------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------
	// No pull on the line, so a released line shows the inverse of its last level
	assign line_o = dev_oe_i ? dev_data_i : (drv_en ? drv_val : ~last_v);
	always @(dev_oe_i or dev_data_i or drv_en or drv_val) begin
		if (dev_oe_i || drv_en) last_v = dev_oe_i ? dev_data_i : drv_val;
	end

	// Clock rests low between frames; reset pin idles high
	initial begin
		reset_pin_n_o = 1'b1;
		clock_o = 1'b0;
		drv_en = 1'b0;
		drv_val = 1'b0;
		last_v = 1'b0;
	end

	// ------------------------------------------------------------
	// Link tasks
	// ------------------------------------------------------------
	// Holding reset low takes the two port pins over
	task automatic enter(input logic on);
		reset_pin_n_o = ~on;
		drv_en = 1'b0;
	endtask

	// Data changes while the clock is low, MSB first
	task automatic send(input logic [27:0] frame);
		for (int i = 27; i >= 0; i--) begin
			drv_en = 1'b1;
			drv_val = frame[i];
			#(HALF_NS) clock_o = 1'b1;
			#(HALF_NS) clock_o = 1'b0;
		end
	endtask

	// Sample the device's answer on each rising edge
	task automatic collect(output logic [14:0] w);
		drv_en = 1'b0; // Line released here and in enter, never in send, so frames can run back to back
		for (int i = 14; i >= 0; i--) begin
			#(HALF_NS) clock_o = 1'b1;
			w[i] = line_o;
			#(HALF_NS) clock_o = 1'b0;
		end
	endtask
endmodule // pmt_programmer

// ==== tb/program_memory_table_read_tb.sv ====
/*
 * Self-checking bench of the program memory and table read block.
 * Assumes the default 2Kx15 geometry and a 10 MHz core clock.
 */
`timescale 1ns/1ps
`include "pmt_params.svh"

module program_memory_table_read_tb;
	import pmt_pkg::*;
	logic                  sys_clk;
	logic                  arst_n;
	logic                  clk_en;
	logic                  fetch_req;
	logic [10:0]           pc;
	logic [14:0]           instr;
	logic                  instr_valid;
	logic                  tbl_req;
	pmt_tbl_req_type       tbl_cmd;
	logic                  busy;
	logic                  done;
	pmt_tbl_res_type       res;
	logic [7:0]            latch;
	logic                  pin_rst_n;
	logic                  pin_clk;
	logic                  line;
	logic                  dev_d;
	logic                  dev_oe;
	logic                  hold;
	logic                  ee_wr;
	logic [7:0]            ee_addr;
	logic [7:0]            ee_data;
	int                    n_errors = 0;
	int                    n_compared = 0;

	pmt_table_read i_dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .clk_en_i(clk_en),
		.fetch_req_i(fetch_req), .pc_i(pc), .instr_o(instr), .instr_valid_o(instr_valid),
		.tbl_req_i(tbl_req), .tbl_cmd_i(tbl_cmd), .tbl_busy_o(busy), .tbl_done_o(done),
		.tbl_res_o(res), .table_high_latch_o(latch), .external_reset_pin_n_i(pin_rst_n),
		.port_a_bit2_prog_clock_i(pin_clk), .port_a_bit0_prog_data_i(line),
		.port_a_bit0_prog_data_o(dev_d), .port_a_bit0_prog_data_oe_o(dev_oe),
		.core_hold_o(hold), .ee_wr_o(ee_wr), .ee_addr_o(ee_addr), .ee_data_o(ee_data));

	pmt_programmer i_prog (.dev_data_i(dev_d), .dev_oe_i(dev_oe), .reset_pin_n_o(pin_rst_n),
		.clock_o(pin_clk), .line_o(line));

	// ------------------------------------------------------------
	// Clock, compare and closing
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Programming: core held, fetch refused, words and EEPROM written, word read back
	task automatic t_program();
		logic [14:0] w;
		logic seen;
		i_prog.enter(1'b1);
		repeat (4) @(negedge sys_clk);
		fetch_req = 1'b1;
		pc = 11'h005;
		repeat (2) @(negedge sys_clk);
		chk(hold, 1'b1);
		chk(instr_valid, 1'b0);
		fetch_req = 1'b0;
		i_prog.send({2'h1, 11'h000, 15'h1234});
		i_prog.send({2'h1, 11'h005, 15'h0abc});
		i_prog.send({2'h1, 11'h706, 15'h7f81});
		i_prog.send({2'h1, 11'h325, 15'h4c3d});
		seen = 1'b0;
		fork
			i_prog.send({2'h2, 11'h0a5, 15'h003c});
			repeat (300) @(negedge sys_clk) if (ee_wr === 1'b1) begin
				seen = 1'b1;
				chk({ee_addr, ee_data}, 16'ha53c);
			end
		join
		chk(seen, 1'b1);
		i_prog.send({2'h0, 11'h706, 15'h0000});
		i_prog.collect(w);
		chk(w, 15'h7f81);
		repeat (8) @(negedge sys_clk);
		chk(dev_oe, 1'b0);
		i_prog.enter(1'b0);
		for (int i = 0; i < 20 && hold !== 1'b0; i++) @(negedge sys_clk);
		chk(hold, 1'b0);
	endtask

	// First fetch goes to the reset entry whatever the counter says
	task automatic t_fetch();
		@(negedge sys_clk);
		fetch_req = 1'b1;
		@(negedge sys_clk);
		chk(instr_valid, 1'b1);
		chk(instr, 15'h1234);
		@(negedge sys_clk);
		fetch_req = 1'b0;
		chk(instr, 15'h0abc);
		@(negedge sys_clk);
		chk(instr_valid, 1'b0);
	endtask

	// Enable low freezes state: a waiting fetch is taken only once it returns
	task automatic t_freeze();
		@(negedge sys_clk);
		clk_en = 1'b0;
		fetch_req = 1'b1;
		pc = 11'h706;
		repeat (3) @(negedge sys_clk);
		chk(instr_valid, 1'b0);
		chk(instr, 15'h0abc);
		clk_en = 1'b1;
		@(negedge sys_clk);
		fetch_req = 1'b0;
		chk(instr_valid, 1'b1);
		chk(instr, 15'h7f81);
	endtask

	// One table read; extra keeps the request up into the busy cycle
	task automatic t_table(input logic cur, input logic [7:0] dest, input logic [7:0] plo,
		input logic [7:0] phi, input logic [14:0] w, input logic extra);
		@(negedge sys_clk);
		tbl_req = 1'b1;
		tbl_cmd = {cur, dest, plo, phi};
		@(negedge sys_clk);
		tbl_req = extra;
		chk({busy, done}, 2'b10);
		@(negedge sys_clk);
		tbl_req = 1'b0;
		chk(done, 1'b1);
		chk(res, {dest, w[7:0]});
		chk(latch, {1'b0, w[14:8]});
		@(negedge sys_clk);
		chk({busy, done}, 2'b00);
		chk(latch, {1'b0, w[14:8]});
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		fetch_req = 1'b0;
		pc = 11'h000;
		tbl_req = 1'b0;
		tbl_cmd = '0;
		repeat (10) @(negedge sys_clk);
		arst_n = 1'b1;
		t_program();
		t_fetch();
		t_freeze();
		t_table(1'b0, 8'h21, 8'h06, 8'hff, 15'h7f81, 1'b1);
		pc = 11'h3f0;
		t_table(1'b1, 8'h42, 8'h25, 8'h07, 15'h4c3d, 1'b0);
		end_of_test();
	end

	// A whole run needs about 160 us; cut a hang long after that
	initial begin
		#3000000;
		n_errors++;
		end_of_test();
	end
endmodule // program_memory_table_read_tb
